// ===== logic/dot_chan.v
// Purpose: One-count down counter channel
// Assumes: tick is a one-cycle count clock enable
// Notes: Trigger waits as pending until next tick
`timescale 1ns/1ps
`default_nettype none
module dot_chan #(
  parameter W = 16
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Control
  input wire tick,
  input wire go_sw,
  input wire stop,
  input wire trig,
  input wire retrig,
  input wire mode_ok,
  input wire [W-1:0] data,
  // State and events
  output reg en_ff,
  output reg run_ff,
  output reg [W-1:0] cnt_ff,
  output reg load_ff,
  output reg zero_ff,
  output reg done_ff
);
  reg pend_ff;
  wire evt;
  wire take;
  // Software start while enabled is also a trigger
  assign evt = en_ff & (trig | go_sw) & (~run_ff | retrig);
  assign take = tick & mode_ok & (pend_ff | evt);
  always @(posedge clk) begin
    if (srst) begin
      en_ff <= 1'b0;
      run_ff <= 1'b0;
      pend_ff <= 1'b0;
      cnt_ff <= {W{1'b0}};
      load_ff <= 1'b0;
      zero_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      load_ff <= 1'b0;
      zero_ff <= 1'b0;
      done_ff <= 1'b0;
      if (stop) begin
        en_ff <= 1'b0;
        run_ff <= 1'b0;
        pend_ff <= 1'b0;
      end else begin
        if (go_sw)
          en_ff <= 1'b1;
        if (take) begin
          cnt_ff <= data;
          run_ff <= 1'b1;
          load_ff <= 1'b1;
          zero_ff <= (data == {W{1'b0}});
          pend_ff <= 1'b0;
        end else begin
          if (evt)
            pend_ff <= 1'b1;
          if (tick & mode_ok & run_ff) begin
            if (cnt_ff == {W{1'b0}}) begin
              done_ff <= 1'b1;
              run_ff <= 1'b0;
            end else begin
              cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
              zero_ff <= (cnt_ff == {{(W-1){1'b0}}, 1'b1});
            end
          end
        end
      end
    end
  end
endmodule // dot_chan
`default_nettype wire

// ===== logic/dot_defines.vh
// Purpose: Constants of the delay and one-shot timer
// Assumes: APB byte addresses, 32-bit data
// Notes: Included by the top module and the bench
`ifndef DOT_DEFINES_VH
`define DOT_DEFINES_VH
// ***************************************
// Register byte addresses
// ***************************************
`define DOT_A_UNIT 8'h00
`define DOT_A_PRESC 8'h04
`define DOT_A_MODE_M 8'h08
`define DOT_A_MODE_S 8'h0C
`define DOT_A_DATA_M 8'h10
`define DOT_A_DATA_S 8'h14
`define DOT_A_CNT_M 8'h18
`define DOT_A_CNT_S 8'h1C
`define DOT_A_TRIG 8'h20
`define DOT_A_STAT 8'h24
`define DOT_A_OUT 8'h28
// ***************************************
// Mode register fields
// ***************************************
`define DOT_F_RETRIG 0
`define DOT_F_MODE_LO 1
`define DOT_F_MODE_HI 3
`define DOT_F_EDGE_LO 6
`define DOT_F_EDGE_HI 7
`define DOT_F_SRC_LO 8
`define DOT_F_SRC_HI 10
`define DOT_F_LEAD 11
`define DOT_F_CCS 12
`define DOT_F_PSEL_LO 14
`define DOT_F_PSEL_HI 15
// ***************************************
// Field encodings
// ***************************************
`define DOT_MODE_ONE 3'h4
`define DOT_EDGE_FALL 2'h0
`define DOT_EDGE_RISE 2'h1
`define DOT_EDGE_BOTH 2'h2
`define DOT_SRC_PIN 3'h1
`define DOT_PSEL_CK0 2'h0
`define DOT_PSEL_CK1 2'h2
// ***************************************
// Trigger, output and unit bits
// ***************************************
`define DOT_T_START_M 0
`define DOT_T_START_S 1
`define DOT_T_STOP_M 2
`define DOT_T_STOP_S 3
`define DOT_O_OE 0
`define DOT_O_POL 1
`define DOT_O_MODE 2
`define DOT_O_LVL 3
`define DOT_U_PWR 0
// ***************************************
// Reset values
// ***************************************
`define DOT_RST_MODE 16'h0000
`define DOT_RST_DATA 16'h0000
`define DOT_RST_PRESC 16'h0000
`endif

// ===== logic/dot_sync.v
// Purpose: Pin synchroniser with edge outputs
// Assumes: Pin is asynchronous to clk
// Notes: Edges come from the settled flops only
`timescale 1ns/1ps
`default_nettype none
module dot_sync (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Pin and edges
  input wire pin,
  output reg rise_ff,
  output reg fall_ff
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  always @(posedge clk) begin
    if (srst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      rise_ff <= s2_ff & ~s3_ff;
      fall_ff <= ~s2_ff & s3_ff;
    end
  end
endmodule // dot_sync
`default_nettype wire

// ===== logic/dot_top.v
// Purpose: Delay counter and one-shot pulse pair
// Assumes: APB slave, one wait state per access
// Notes: Clearing unit power resets all but the bus, unit power, pin output and interrupt flops
// Notes on behaviour
// R1: Start bit enables channel, awaits trigger
// R2: Start and stop bits self-clear
// R3: Valid edge loads data into count
// R4: Count down, interrupt at zero, halt
// R5: Data writable, count readable anytime
// R6: Stop bit clears enable, keeps count
// R7: Power off resets all, refuses writes
// R8: Delay is master data plus two
// R9: Pulse width is slave data
// R10: Master one-count, reload per trigger
// R11: Slave triggered by master interrupt
// R12: Output active after master interrupt
// R13: Software start also triggers master
// R14: Software rewrites data after interrupts
// R15: Mode 100B; triggers ignored while counting
// R16: Edge select fall, rise, both
// R17: Source 001B selects pin edge
// R18: Pair leader bit, zero on channel 0
// R19: Prescaler select picks clock 0 or 1
// R20: Polarity bit sets output sense
// R21: Output mode bit selects slave output
// R22: Output enable lets counting drive output
// R23: All counting gated by count clock
`timescale 1ns/1ps
`default_nettype none
`include "dot_defines.vh"
module dot_top #(
  parameter W = 16,
  parameter CHAN_NUM = 2
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_ff,
  output reg pready_ff,
  output reg pslverr_ff,
  // Timer pins
  input wire timer_input_pin,
  output reg pulse_output_ff,
  // Interrupt events
  output reg channel_done_interrupt_ff,
  output reg slave_done_interrupt_ff
);
  // ***************************************
  // Register state
  // ***************************************
  reg unit_power_enable_ff;
  reg [15:0] prescaler_config_ff;
  reg [15:0] mode_m_ff;
  reg [15:0] mode_s_ff;
  reg [W-1:0] data_m_ff;
  reg [W-1:0] data_s_ff;
  reg output_enable_bit_ff;
  reg output_polarity_bit_ff;
  reg output_mode_bit_ff;
  reg out_level_ff;
  reg [7:0] div0_ff;
  reg [7:0] div1_ff;
  reg ck0_ff;
  reg ck1_ff;
  reg go_m_ff;
  reg go_s_ff;
  reg stop_m_ff;
  reg stop_s_ff;
  // ***************************************
  // Bus decode
  // ***************************************
  wire rst_i;
  wire acc;
  wire wr;
  reg hit;
  reg [31:0] nxt_rdata;
  wire en_m;
  wire en_s;
  wire run_m;
  wire run_s;
  wire [W-1:0] cnt_m;
  wire [W-1:0] cnt_s;
  // Power off acts as a reset of every channel circuit
  assign rst_i = srst | ~unit_power_enable_ff; // see R7
  assign acc = psel & penable & ~pready_ff;
  assign wr = psel & penable & pready_ff & pwrite & ~pslverr_ff;
  always @* begin
    hit = 1'b1;
    nxt_rdata = 32'h00000000;
    if (paddr == `DOT_A_UNIT) begin
      nxt_rdata[`DOT_U_PWR] = unit_power_enable_ff;
    end else if (paddr == `DOT_A_PRESC) begin
      nxt_rdata[15:0] = prescaler_config_ff;
    end else if (paddr == `DOT_A_MODE_M) begin
      nxt_rdata[15:0] = mode_m_ff;
    end else if (paddr == `DOT_A_MODE_S) begin
      nxt_rdata[15:0] = mode_s_ff;
    end else if (paddr == `DOT_A_DATA_M) begin
      nxt_rdata[W-1:0] = data_m_ff;
    end else if (paddr == `DOT_A_DATA_S) begin
      nxt_rdata[W-1:0] = data_s_ff;
    end else if (paddr == `DOT_A_CNT_M) begin
      nxt_rdata[W-1:0] = cnt_m; // see R5
    end else if (paddr == `DOT_A_CNT_S) begin
      nxt_rdata[W-1:0] = cnt_s;
    end else if (paddr == `DOT_A_TRIG) begin
      nxt_rdata = 32'h00000000; // see R2
    end else if (paddr == `DOT_A_STAT) begin
      nxt_rdata[0] = en_m;
      nxt_rdata[1] = en_s;
      nxt_rdata[2] = run_m;
      nxt_rdata[3] = run_s;
    end else if (paddr == `DOT_A_OUT) begin
      nxt_rdata[`DOT_O_OE] = output_enable_bit_ff;
      nxt_rdata[`DOT_O_POL] = output_polarity_bit_ff;
      nxt_rdata[`DOT_O_MODE] = output_mode_bit_ff;
      nxt_rdata[`DOT_O_LVL] = out_level_ff;
    end else begin
      hit = 1'b0;
    end
  end
  // One wait state keeps every bus output on a flop
  always @(posedge clk) begin
    if (srst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= acc;
      pslverr_ff <= acc & ~hit;
      if (acc)
        prdata_ff <= nxt_rdata;
    end
  end
  // ***************************************
  // Unit power bit
  // ***************************************
  always @(posedge clk) begin
    if (srst)
      unit_power_enable_ff <= 1'b0;
    else if (wr && paddr == `DOT_A_UNIT)
      unit_power_enable_ff <= pwdata[`DOT_U_PWR];
  end
  // ***************************************
  // Configuration registers
  // ***************************************
  wire lead_m;
  // Writes land only while powered
  always @(posedge clk) begin
    if (rst_i) begin
      prescaler_config_ff <= `DOT_RST_PRESC; // see R7
      mode_m_ff <= `DOT_RST_MODE;
      mode_s_ff <= `DOT_RST_MODE;
      data_m_ff <= `DOT_RST_DATA;
      data_s_ff <= `DOT_RST_DATA;
      output_enable_bit_ff <= 1'b0;
      output_polarity_bit_ff <= 1'b0;
      output_mode_bit_ff <= 1'b0;
    end else if (wr) begin
      if (paddr == `DOT_A_PRESC)
        prescaler_config_ff <= pwdata[15:0];
      if (paddr == `DOT_A_MODE_M)
        mode_m_ff <= pwdata[15:0];
      if (paddr == `DOT_A_MODE_S)
        mode_s_ff <= pwdata[15:0];
      if (paddr == `DOT_A_DATA_M)
        data_m_ff <= pwdata[W-1:0]; // see R5
      if (paddr == `DOT_A_DATA_S)
        data_s_ff <= pwdata[W-1:0];
      if (paddr == `DOT_A_OUT) begin
        output_enable_bit_ff <= pwdata[`DOT_O_OE];
        output_polarity_bit_ff <= pwdata[`DOT_O_POL];
        output_mode_bit_ff <= pwdata[`DOT_O_MODE];
      end
    end
  end
  // Channel 0 cannot lead a pair
  assign lead_m = (CHAN_NUM != 0) & mode_m_ff[`DOT_F_LEAD]; // see R18
  // ***************************************
  // Trigger bits
  // ***************************************
  // Pulses only, so the bits read back as zero
  always @(posedge clk) begin
    if (rst_i) begin
      go_m_ff <= 1'b0;
      go_s_ff <= 1'b0;
      stop_m_ff <= 1'b0;
      stop_s_ff <= 1'b0;
    end else begin
      go_m_ff <= wr && paddr == `DOT_A_TRIG && pwdata[`DOT_T_START_M]; // see R2
      go_s_ff <= wr && paddr == `DOT_A_TRIG && pwdata[`DOT_T_START_S];
      stop_m_ff <= wr && paddr == `DOT_A_TRIG && pwdata[`DOT_T_STOP_M]; // see R6
      stop_s_ff <= wr && paddr == `DOT_A_TRIG && pwdata[`DOT_T_STOP_S];
    end
  end
  // ***************************************
  // Prescaled clocks
  // ***************************************
  // Divide by field value plus one
  always @(posedge clk) begin
    if (rst_i) begin
      div0_ff <= 8'h00;
      div1_ff <= 8'h00;
      ck0_ff <= 1'b0;
      ck1_ff <= 1'b0;
    end else begin
      ck0_ff <= (div0_ff == prescaler_config_ff[7:0]);
      ck1_ff <= (div1_ff == prescaler_config_ff[15:8]);
      if (div0_ff == prescaler_config_ff[7:0])
        div0_ff <= 8'h00;
      else
        div0_ff <= div0_ff + 8'h01;
      if (div1_ff == prescaler_config_ff[15:8])
        div1_ff <= 8'h00;
      else
        div1_ff <= div1_ff + 8'h01;
    end
  end
  // ***************************************
  // Input edge and count clock select
  // ***************************************
  wire pin_rise;
  wire pin_fall;
  reg edge_m;
  reg tick_m;
  reg tick_s;
  dot_sync u_sync (
    .clk(clk),
    .srst(rst_i),
    .pin(timer_input_pin),
    .rise_ff(pin_rise),
    .fall_ff(pin_fall)
  );
  always @* begin
    edge_m = 1'b0;
    case (mode_m_ff[`DOT_F_EDGE_HI:`DOT_F_EDGE_LO])
      `DOT_EDGE_FALL: edge_m = pin_fall; // see R16
      `DOT_EDGE_RISE: edge_m = pin_rise;
      `DOT_EDGE_BOTH: edge_m = pin_rise | pin_fall;
      default: edge_m = 1'b0;
    endcase
  end
  // Other select codes give no count clock unless the CCS bit picks the pin edge
  always @* begin
    tick_m = 1'b0;
    tick_s = 1'b0;
    case (mode_m_ff[`DOT_F_PSEL_HI:`DOT_F_PSEL_LO])
      `DOT_PSEL_CK0: tick_m = ck0_ff; // see R19
      `DOT_PSEL_CK1: tick_m = ck1_ff;
      default: tick_m = 1'b0;
    endcase
    case (mode_s_ff[`DOT_F_PSEL_HI:`DOT_F_PSEL_LO])
      `DOT_PSEL_CK0: tick_s = ck0_ff;
      `DOT_PSEL_CK1: tick_s = ck1_ff;
      default: tick_s = 1'b0;
    endcase
    if (mode_m_ff[`DOT_F_CCS])
      tick_m = edge_m;
    if (mode_s_ff[`DOT_F_CCS])
      tick_s = edge_m;
  end
  // ***************************************
  // Master and slave channels
  // ***************************************
  wire trig_m;
  wire trig_s;
  wire ok_m;
  wire ok_s;
  wire load_s;
  wire zero_s;
  wire done_m;
  wire done_s;
  // Pin edge only when the source field picks it
  assign trig_m = (mode_m_ff[`DOT_F_SRC_HI:`DOT_F_SRC_LO] == `DOT_SRC_PIN) & edge_m; // see R17
  // Slave takes the master interrupt as its trigger
  assign trig_s = lead_m ? done_m : 1'b0; // see R11
  assign ok_m = (mode_m_ff[`DOT_F_MODE_HI:`DOT_F_MODE_LO] == `DOT_MODE_ONE); // see R15
  assign ok_s = (mode_s_ff[`DOT_F_MODE_HI:`DOT_F_MODE_LO] == `DOT_MODE_ONE);
  // Pending trigger plus load tick give data plus two
  dot_chan #(.W(W)) u_master ( // see R8
    .clk(clk),
    .srst(rst_i),
    .tick(tick_m), // see R23
    .go_sw(go_m_ff), // see R1
    .stop(stop_m_ff),
    .trig(trig_m), // see R13
    .retrig(mode_m_ff[`DOT_F_RETRIG]),
    .mode_ok(ok_m), // see R10
    .data(data_m_ff), // see R3
    .en_ff(en_m),
    .run_ff(run_m),
    .cnt_ff(cnt_m), // see R4
    .load_ff(),
    .zero_ff(),
    .done_ff(done_m)
  );
  dot_chan #(.W(W)) u_slave (
    .clk(clk),
    .srst(rst_i),
    .tick(tick_s),
    .go_sw(go_s_ff),
    .stop(stop_s_ff),
    .trig(trig_s),
    .retrig(mode_s_ff[`DOT_F_RETRIG]),
    .mode_ok(ok_s),
    .data(data_s_ff), // see R9
    .en_ff(en_s),
    .run_ff(run_s),
    .cnt_ff(cnt_s),
    .load_ff(load_s),
    .zero_ff(zero_s),
    .done_ff(done_s)
  );
  // ***************************************
  // Pulse output
  // ***************************************
  wire drive;
  wire lvl_wr;
  assign drive = output_enable_bit_ff & output_mode_bit_ff; // see R21
  // Level bit is software's only while the output enable bit is clear
  assign lvl_wr = wr && paddr == `DOT_A_OUT && ~output_enable_bit_ff;
  always @(posedge clk) begin
    if (rst_i) begin
      out_level_ff <= 1'b0;
    end else if (drive) begin // see R22
      if (zero_s)
        out_level_ff <= output_polarity_bit_ff; // see R12
      else if (load_s)
        out_level_ff <= ~output_polarity_bit_ff; // see R20
    end else if (lvl_wr) begin
      out_level_ff <= pwdata[`DOT_O_LVL];
    end
  end
  // Stop keeps the last level rather than forcing idle
  always @(posedge clk) begin
    if (srst) begin
      pulse_output_ff <= 1'b0;
      channel_done_interrupt_ff <= 1'b0;
      slave_done_interrupt_ff <= 1'b0;
    end else begin
      pulse_output_ff <= out_level_ff;
      channel_done_interrupt_ff <= done_m; // see R4
      slave_done_interrupt_ff <= done_s;
    end
  end
endmodule // dot_top
`default_nettype wire

// ===== tb/dot_checker.sv
// Purpose: Port checks for the delay and one-shot timer
// Assumes: Slave done follows master done within 2 to 255 cycles
// Notes: Bound to every dot_top instance
`timescale 1ns/1ps
`default_nettype none
module dot_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata_ff,
  input wire logic pready_ff,
  input wire logic pslverr_ff,
  // Timer
  input wire logic pulse_output_ff,
  input wire logic channel_done_interrupt_ff,
  input wire logic slave_done_interrupt_ff
);
  // ***************************************
  // Assertions
  // ***************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // Saturates so a slave done with no master done behind it shows up
  logic [7:0] since_m_ff;
  always_ff @(posedge clk) begin
    if (srst) begin
      since_m_ff <= 8'hFF;
    end else if (channel_done_interrupt_ff) begin
      since_m_ff <= 8'h00;
    end else if (since_m_ff != 8'hFF) begin
      since_m_ff <= since_m_ff + 8'h01;
    end
  end
  a_ready_after_access: assert property (psel && penable && !pready_ff |=> pready_ff)
    else $error("pready missing after access");
  a_ready_one_cycle: assert property (pready_ff |=> !pready_ff)
    else $error("pready longer than one cycle");
  a_ready_has_cause: assert property (pready_ff |-> $past(psel && penable))
    else $error("pready without access");
  a_error_reads_zero: assert property (pslverr_ff |-> pready_ff && prdata_ff == 32'h00000000)
    else $error("error answer malformed");
  a_done_single: assert property (channel_done_interrupt_ff |=> !channel_done_interrupt_ff)
    else $error("master done longer than one cycle");
  a_slave_done_single: assert property (slave_done_interrupt_ff |=> !slave_done_interrupt_ff)
    else $error("slave done longer than one cycle");
  a_slave_after_master: assert property (slave_done_interrupt_ff |-> since_m_ff != 8'h00 && since_m_ff != 8'hFF)
    else $error("slave done without master done");
  a_reset_quiet: assert property ($past(srst) |-> !(pready_ff || pulse_output_ff || channel_done_interrupt_ff))
    else $error("output active after reset");
  cover property (channel_done_interrupt_ff);
  cover property (slave_done_interrupt_ff);
  cover property (pslverr_ff);
  cover property ($rose(pulse_output_ff));
endmodule // dot_checker
bind dot_top dot_checker dot_checker_inst (.clk, .srst, .psel, .penable, .prdata_ff, .pready_ff, .pslverr_ff,
  .pulse_output_ff, .channel_done_interrupt_ff, .slave_done_interrupt_ff);
`default_nettype wire

// ===== tb/dot_pin_model.sv
// Purpose: Trigger source and pulse load at the timer pins
// Assumes: One pin toggle per fire cycle
// Notes: Pin is actively driven, so it holds between toggles
`timescale 1ns/1ps
`default_nettype none
module dot_pin_model (
  // Clock
  input wire logic clk,
  // Bench control
  input wire logic fire,
  // Pins
  input wire logic pulse,
  output var logic pin,
  // Observation
  output var int width
);
  // ***************************************
  // Pin drive and pulse measurement
  // ***************************************
  initial begin
    pin = 1'b0;
    width = 0;
  end
  always @(posedge clk) begin
    if (fire) begin
      pin <= ~pin;
    end
    if (pulse) begin
      width <= width + 1;
    end
  end
endmodule // dot_pin_model
`default_nettype wire

// ===== tb/dot_tb_top.sv
// Purpose: Self-checking bench for the delay and one-shot timer
// Assumes: Prescaler 0 ticks every cycle, prescaler 1 every second
// Notes: Delay is checked as a difference, so fixed latency cancels
`timescale 1ns/1ps
`default_nettype none
`include "dot_defines.vh"
module dot_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic fire = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata_ff, q, r, c1;
  logic pready_ff, pslverr_ff, e, pin, pulse_output_ff, channel_done_interrupt_ff, slave_done_interrupt_ff;
  int failures = 0;
  int n_checks = 0;
  int n_md = 0;
  int n_sd = 0;
  int width, md;
  int lat[3];
  int dd[3] = '{2, 5, 4};
  int ss[3] = '{3, 3, 2};
  int pp[3] = '{0, 0, 1};
  int eg[5] = '{0, 1, 2, 2, 3};
  int gp[5] = '{40, 40, 40, 2, 40};
  int ex[5] = '{1, 1, 2, 1, 0};
  always #2.5 clk = ~clk;
  dot_top dot_top_inst (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_ff, .pready_ff,
    .pslverr_ff, .timer_input_pin(pin), .pulse_output_ff, .channel_done_interrupt_ff, .slave_done_interrupt_ff);
  dot_pin_model dot_pin_model_inst (.clk, .fire, .pulse(pulse_output_ff), .pin, .width);
  always @(posedge clk) begin
    if (channel_done_interrupt_ff === 1'b1) n_md <= n_md + 1;
    if (slave_done_interrupt_ff === 1'b1) n_sd <= n_sd + 1;
  end
  // ***************************************
  // Tasks
  // ***************************************
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    while (pready_ff !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) failures++;
    q = prdata_ff;
    e = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic shot(input int d, input int s, input int pv, output int l);
    int w0, sd, k;
    md = n_md;
    wr(`DOT_A_DATA_M, d);
    wr(`DOT_A_DATA_S, s);
    wr(`DOT_A_MODE_M, 32'h0948 | (pv << 15));
    wr(`DOT_A_MODE_S, 32'h0008 | (pv << 15));
    w0 = width;
    sd = n_sd;
    wr(`DOT_A_TRIG, 32'h1);
    l = 0;
    k = 0;
    while (pulse_output_ff !== 1'b1 && l < 300) begin
      @(posedge clk);
      l++;
    end
    while (n_sd == sd && k < 300) begin
      @(posedge clk);
      k++;
    end
    if (l >= 300 || k >= 300) failures++;
    repeat (3) @(posedge clk);
    chk("pulse width", s * (pv + 1), width - w0);
    chk("slave done", sd + 1, n_sd);
    chk("master done", md + 1, n_md);
    xfer(1'b0, `DOT_A_CNT_M, 32'h0);
    chk("count at end", 32'h0, q);
  endtask
  // ***************************************
  // Main sequence
  // ***************************************
  initial begin
    void'($urandom(34));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    xfer(1'b0, `DOT_A_MODE_M, 32'h0);
    chk("mode reset", 32'h0, q);
    wr(`DOT_A_DATA_M, 32'h7);
    xfer(1'b0, `DOT_A_DATA_M, 32'h0);
    chk("write while off", 32'h0, q);
    wr(`DOT_A_UNIT, 32'h1);
    r = $urandom & 32'hFFFF;
    wr(`DOT_A_DATA_S, r);
    xfer(1'b0, `DOT_A_DATA_S, 32'h0);
    chk("data readback", r, q);
    xfer(1'b0, 8'h3C, 32'h0);
    chk("unmapped error", 32'h1, e);
    wr(`DOT_A_PRESC, 32'h0100);
    wr(`DOT_A_OUT, 32'h5);
    wr(`DOT_A_TRIG, 32'h3);
    xfer(1'b0, `DOT_A_STAT, 32'h0);
    chk("enabled", 32'h3, q & 32'h3);
    for (int i = 0; i < 3; i++) begin
      shot(dd[i], ss[i], pp[i], lat[i]);
    end
    chk("delay step", 32'h3, lat[1] - lat[0]);
    wr(`DOT_A_OUT, 32'h7);
    wr(`DOT_A_DATA_M, 32'h6);
    for (int i = 0; i < 5; i++) begin
      md = n_md;
      wr(`DOT_A_MODE_M, 32'h0908 | (eg[i] << 6));
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (gp[i]) @(posedge clk);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (40) @(posedge clk);
      chk("pin triggers", md + ex[i], n_md);
    end
    chk("active-low idle", 32'h1, pulse_output_ff);
    wr(`DOT_A_DATA_M, 32'd40);
    wr(`DOT_A_MODE_M, 32'h0948);
    wr(`DOT_A_TRIG, 32'h1);
    repeat (10) @(posedge clk);
    wr(`DOT_A_TRIG, 32'h4);
    xfer(1'b0, `DOT_A_CNT_M, 32'h0);
    c1 = q;
    repeat (5) @(posedge clk);
    xfer(1'b0, `DOT_A_CNT_M, 32'h0);
    chk("count held", c1, q);
    chk("count nonzero", 32'h1, c1 != 32'h0);
    xfer(1'b0, `DOT_A_STAT, 32'h0);
    chk("stopped", 32'h0, q & 32'h1);
    wr(`DOT_A_OUT, 32'h0);
    repeat (2) @(posedge clk);
    chk("level held", 32'h1, pulse_output_ff);
    wr(`DOT_A_OUT, 32'h0);
    repeat (2) @(posedge clk);
    chk("level cleared", 32'h0, pulse_output_ff);
    wr(`DOT_A_OUT, 32'h8);
    repeat (3) @(posedge clk);
    chk("output level", 32'h1, pulse_output_ff);
    wr(`DOT_A_UNIT, 32'h0);
    repeat (3) @(posedge clk);
    chk("output off", 32'h0, pulse_output_ff);
    xfer(1'b0, `DOT_A_DATA_S, 32'h0);
    chk("data cleared", 32'h0, q);
    wr(`DOT_A_UNIT, 32'h1);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    xfer(1'b0, `DOT_A_UNIT, 32'h0);
    chk("unit after reset", 32'h0, q);
    conclude();
  end
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule // dot_tb_top
`default_nettype wire
